/* File: arr_regs.sv */
// Group-B input range register bank behind an Avalon-MM slave.
// Assumes a single 50 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
module arr_regs (
    input  wire logic                         clk_sys,
    input  wire logic                         sys_rst,
    input  wire logic [arr_pkg::ARR_ADDR_W-1:0] avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [arr_pkg::ARR_DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic      [arr_pkg::ARR_DATA_W-1:0] avs_readdata,
    output logic                              avs_waitrequest,
    output logic      [15:0]                  range_code,
    output logic      [15:0]                  range_sel
);
    import arr_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [8:0]            body_low;        // Lower reg, bits 8:0
    logic [8:0]            body_high;       // Upper reg, bits 8:0
    logic [8:0]            next_body_low;   // Next lower body
    logic [8:0]            next_body_high;  // Next upper body
    logic                  ack;             // Access completes this cycle
    logic                  next_ack;        // Next ack
    logic [ARR_DATA_W-1:0] next_readdata;   // Next read data
    logic                  req;             // A request is pending
    logic                  hit_low;         // Address selects lower reg
    logic                  hit_high;        // Address selects upper reg
    logic [6:0]            wr_tag;          // Address field of write data
    logic                  lanes_ok;        // Both low byte lanes enabled

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign req      = avs_read | avs_write;
    assign hit_low  = (avs_address == ARR_OFS_B_LOW);
    assign hit_high = (avs_address == ARR_OFS_B_HIGH);
    assign wr_tag   = avs_writedata[ARR_ADDR_FIELD_MSB:ARR_ADDR_FIELD_LSB];
    assign lanes_ok = avs_byteenable[0] & avs_byteenable[1];

    // One wait cycle, then the access completes
    assign avs_waitrequest = req & ~ack;

    // ------------------------------------------------------------------
    // Handshake and read path
    // ------------------------------------------------------------------
    // Ack rises one cycle after the request and drops after completion
    always_comb begin
        next_ack      = req & ~ack;
        next_readdata = avs_readdata;
        if (avs_read && !ack) begin
            // Read word carries the register's own index on top
            if (hit_low) begin
                next_readdata = {16'h0000, ARR_IDX_B_LOW, body_low};
            end else if (hit_high) begin
                next_readdata = {16'h0000, ARR_IDX_B_HIGH, body_high};
            end else begin
                // Unmapped address reads zero
                next_readdata = '0;
            end
        end
    end

    // Registers the handshake and read data
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ack          <= 1'b0;
            avs_readdata <= '0;
        end else begin
            ack          <= next_ack;
            avs_readdata <= next_readdata;
        end
    end

    // ------------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------------
    // A write lands on the completing edge when both low byte lanes are enabled
    // and the word's address field matches the register selected by the bus address
    always_comb begin
        next_body_low  = body_low;
        next_body_high = body_high;
        if (avs_write && ack && lanes_ok) begin
            if (hit_low && wr_tag == ARR_IDX_B_LOW) begin
                // Reserved bit stored as written
                next_body_low = avs_writedata[8:0];
            end else if (hit_high && wr_tag == ARR_IDX_B_HIGH) begin
                next_body_high = avs_writedata[8:0];
            end else begin
                // Mismatched tag or unmapped address: ignored
                next_body_low  = body_low;
                next_body_high = body_high;
            end
        end
    end

    // Registers both range words, defaulting to the widest range
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            body_low  <= ARR_RESET_BODY;
            body_high <= ARR_RESET_BODY;
        end else begin
            body_low  <= next_body_low;
            body_high <= next_body_high;
        end
    end

    // ------------------------------------------------------------------
    // Channel fields
    // ------------------------------------------------------------------
    // Lower word feeds channels 0-3, upper word channels 4-7
    assign range_code[1:0]   = body_low[1:0];
    assign range_code[3:2]   = body_low[3:2];
    assign range_code[5:4]   = body_low[5:4];
    assign range_code[7:6]   = body_low[7:6];
    assign range_code[9:8]   = body_high[1:0];
    assign range_code[11:10] = body_high[3:2];
    assign range_code[13:12] = body_high[5:4];
    assign range_code[15:14] = body_high[7:6];

    // One decoder per channel
    genvar ch;
    generate
        for (ch = 0; ch < ARR_NUM_CH; ch++) begin : g_ch
            arr_range_if link ();
            assign link.code = range_code[2*ch +: 2];
            arr_range_dec u_dec (
                .port (link.dec)
            );
            assign range_sel[2*ch +: 2] = link.range;
        end
    endgenerate
endmodule

/* File: arr_pkg.sv */
// Shared constants and types for the group-B input range register bank.
// Assumes a 32-bit Avalon-MM slave port with byte addressing.
package arr_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ARR_ADDR_W        = 8;   // Byte address width
    localparam int          ARR_DATA_W        = 32;  // Bus data width
    localparam int          ARR_REG_W         = 16;  // Range register width
    localparam logic [6:0]  ARR_IDX_B_LOW     = 7'h06; // Lower reg index
    localparam logic [6:0]  ARR_IDX_B_HIGH    = 7'h07; // Upper reg index
    // Byte address is four times the index
    localparam logic [7:0]  ARR_OFS_B_LOW     = {ARR_IDX_B_LOW[5:0], 2'b00};
    localparam logic [7:0]  ARR_OFS_B_HIGH    = {ARR_IDX_B_HIGH[5:0], 2'b00};

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int          ARR_ADDR_FIELD_MSB = 15; // Register address field
    localparam int          ARR_ADDR_FIELD_LSB = 9;
    localparam int          ARR_RSVD_BIT       = 8;  // Reserved bit
    localparam int          ARR_FIELD_W        = 2;  // Width of a range field
    localparam int          ARR_CH_PER_REG     = 4;  // Fields per register
    localparam int          ARR_NUM_CH         = 8;  // Group-B channels
    // Stored bits of a register: reserved bit plus four range fields
    localparam logic [8:0]  ARR_RESET_BODY     = 9'h0ff;
    localparam logic [15:0] ARR_RESET_VALUE    = 16'h00ff;
    localparam logic [1:0]  ARR_FIELD_RESET    = 2'h3;

    // ------------------------------------------------------------------
    // Range encodings
    // ------------------------------------------------------------------
    localparam logic [1:0]  ARR_CODE_10V_A     = 2'h0; // +/-10 V
    localparam logic [1:0]  ARR_CODE_2V5       = 2'h1; // +/-2.5 V
    localparam logic [1:0]  ARR_CODE_5V        = 2'h2; // +/-5 V
    localparam logic [1:0]  ARR_CODE_10V_B     = 2'h3; // +/-10 V

    // Decoded range seen by the analog front end
    typedef enum logic [1:0] {
        ARR_RANGE_10V = 2'b00,
        ARR_RANGE_5V  = 2'b01,
        ARR_RANGE_2V5 = 2'b10
    } arr_range_t;

endpackage

/* File: arr_range_if.sv */
// Carrier between the register bank and one channel's range decoder.
// Assumes the code comes from a register and the range is combinational.
`timescale 1ns/1ps
interface arr_range_if;
    import arr_pkg::*;
    logic [1:0] code;   // Raw two-bit range field
    arr_range_t range;  // Decoded range

    modport bank (output code, input range);
    modport dec  (input code, output range);
endinterface

/* File: arr_range_dec.sv */
// Decoder from one two-bit range field to the selected input range.
// Assumes the field is held stable in a register by the bank.
`timescale 1ns/1ps
module arr_range_dec (
    arr_range_if.dec port
);
    import arr_pkg::*;

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    // Both 00 and 11 map to the widest range
    always_comb begin
        case (port.code)
            ARR_CODE_10V_A: port.range = ARR_RANGE_10V;
            ARR_CODE_2V5:   port.range = ARR_RANGE_2V5;
            ARR_CODE_5V:    port.range = ARR_RANGE_5V;
            ARR_CODE_10V_B: port.range = ARR_RANGE_10V;
            default:        port.range = ARR_RANGE_10V;
        endcase
    end
endmodule

/* File: arr_regs_assertions.sv */
// Port checker for the group-B range register bank.
// Assumes it is bound to arr_regs; one clock, synchronous reset.
`timescale 1ns/1ps
module arr_regs_assertions (
    input wire logic                           clk_sys,
    input wire logic                           sys_rst,
    input wire logic [arr_pkg::ARR_ADDR_W-1:0] avs_address,
    input wire logic                           avs_read,
    input wire logic                           avs_write,
    input wire logic [arr_pkg::ARR_DATA_W-1:0] avs_writedata,
    input wire logic [3:0]                     avs_byteenable,
    input wire logic [arr_pkg::ARR_DATA_W-1:0] avs_readdata,
    input wire logic                           avs_waitrequest,
    input wire logic [15:0]                    range_code,
    input wire logic [15:0]                    range_sel
);
    import arr_pkg::*;
    logic        acc;     // Write accepted this edge with both low byte lanes enabled
    logic        wlo;     // Accepted write that lands in the low reg
    logic        whi;     // Accepted write that lands in the high reg
    logic        rd;      // Read accepted this edge
    logic [15:0] exp_sel; // Decoded ranges expected from the codes
    assign acc = avs_write && !avs_waitrequest && &avs_byteenable[1:0];
    assign wlo = acc && avs_address == ARR_OFS_B_LOW
                 && avs_writedata[15:9] == ARR_IDX_B_LOW;
    assign whi = acc && avs_address == ARR_OFS_B_HIGH
                 && avs_writedata[15:9] == ARR_IDX_B_HIGH;
    assign rd  = avs_read && !avs_waitrequest;
    // Per channel: code 01 picks 2.5 V, code 10 picks 5 V
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            exp_sel[2*i+1] = range_code[2*i+:2] == ARR_CODE_2V5;
            exp_sel[2*i]   = range_code[2*i+:2] == ARR_CODE_5V;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request held over one wait");
    a_idle_free: assert property (!(avs_read || avs_write)
        |-> !avs_waitrequest) else $error("wait raised while idle");
    a_low_store: assert property (wlo
        |=> range_code[7:0] == $past(avs_writedata[7:0]))
        else $error("low fields not stored");
    a_high_store: assert property (whi
        |=> range_code[15:8] == $past(avs_writedata[7:0]))
        else $error("high fields not stored");
    a_bad_ignored: assert property (avs_write && !avs_waitrequest
        && !wlo && !whi |=> $stable(range_code))
        else $error("refused write changed fields");
    a_sel_decode: assert property (range_sel == exp_sel)
        else $error("range decode wrong");
    a_reset_value: assert property ($past(sys_rst)
        |-> range_code == 16'hffff && range_sel == 16'h0000)
        else $error("reset value wrong");
    a_read_low: assert property (rd && avs_address == ARR_OFS_B_LOW
        |-> avs_readdata[15:9] == ARR_IDX_B_LOW
        && avs_readdata[7:0] == range_code[7:0]) else $error("low read wrong");
    a_read_unmap: assert property (rd && avs_address != ARR_OFS_B_LOW
        && avs_address != ARR_OFS_B_HIGH |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind arr_regs arr_regs_assertions arr_regs_assertions_inst (.clk_sys,
    .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .range_code,
    .range_sel);

/* File: arr_host.sv */
// Host controller model acting as the Avalon-MM master.
// Assumes the slave answers with waitrequest; holds until it drops or 64 cycles pass.
`timescale 1ns/1ps
module arr_host (
    input  wire logic                    clk_sys,
    input  wire logic                    avs_waitrequest,
    input  wire logic [31:0]             avs_readdata,
    output logic      [7:0]              avs_address,
    output logic                         avs_read,
    output logic                         avs_write,
    output logic      [31:0]             avs_writedata,
    output logic      [3:0]              avs_byteenable
);
    initial {avs_address, avs_read, avs_write, avs_writedata} = '0;
    initial avs_byteenable = 4'h0;
    // One access; caller supplies the index in bits 15:9
    task automatic xfer(input bit wr, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] q, output bit ok);
        int n;
        n = 0;
        avs_address    <= a;
        avs_writedata  <= {d[31:9], 1'b0, d[7:0]};
        avs_byteenable <= be;
        avs_read       <= !wr;
        avs_write      <= wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest && n < 64);
        ok = !avs_waitrequest;
        q  = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
endmodule

/* File: tb_arr_regs.sv */
// Testbench for the group-B range register bank.
// Assumes arr_host as bus master and the bound port checker.
`timescale 1ns/1ps
module tb_arr_regs;
    import arr_pkg::*;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic [15:0] range_code, range_sel;
    int          fail_count = 0;
    int          checks = 0;
    always #10 clk_sys = ~clk_sys;
    arr_regs arr_regs_inst (.clk_sys, .sys_rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .range_code, .range_sel);
    arr_host arr_host_inst (.clk_sys, .avs_waitrequest, .avs_readdata,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable);
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic bus(bit wr, logic [7:0] a, logic [31:0] d,
        logic [3:0] be, output logic [31:0] q);
        bit ok;
        arr_host_inst.xfer(wr, a, d, be, q, ok);
        if (!ok) begin
            chk("timeout", 32'h0, 32'h1);
            end_sim();
        end
    endtask
    function automatic logic [15:0] sel_of(logic [15:0] c);
        for (int i = 0; i < 8; i++)
            sel_of[2*i+:2] = c[2*i+:2] == ARR_CODE_2V5 ? ARR_RANGE_2V5 :
                c[2*i+:2] == ARR_CODE_5V ? ARR_RANGE_5V : ARR_RANGE_10V;
    endfunction
    // Reset for four cycles, then check reset values
    task automatic t_reset();
        logic [31:0] q;
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        chk("code", {16'h0, range_code}, 32'hffff);
        chk("sel", {16'h0, range_sel}, 32'h0);
        bus(0, ARR_OFS_B_LOW, 32'h0, 4'hf, q);
        chk("rd low", q, 32'h0000_0cff);
        bus(0, ARR_OFS_B_HIGH, 32'h0, 4'hf, q);
        chk("rd high", q, 32'h0000_0eff);
        $display("reset test done");
    endtask
    // Every code in every field, back to back
    task automatic t_codes();
        logic [31:0] q;
        logic [7:0]  lo, hi;
        for (int c = 0; c < 4; c++) begin
            // Each field gets its own code, so a swapped field shows up
            lo = {2'(c), 2'(c + 1), 2'(c + 2), 2'(c + 3)};
            hi = ~lo;
            bus(1, ARR_OFS_B_LOW, {16'h0, ARR_IDX_B_LOW, 1'b0, lo}, 4'hf, q);
            bus(1, ARR_OFS_B_HIGH, {16'h0, ARR_IDX_B_HIGH, 1'b0, hi}, 4'h3, q);
            chk("code", {16'h0, range_code}, {16'h0, hi, lo});
            chk("sel", {16'h0, range_sel}, {16'h0, sel_of({hi, lo})});
            bus(0, ARR_OFS_B_HIGH, 32'h0, 4'hf, q);
            chk("rd high", q, {16'h0, ARR_IDX_B_HIGH, 1'b0, hi});
        end
        $display("code test done");
    endtask
    // Wrong index, missing lane and unmapped place leave fields alone
    task automatic t_refuse();
        logic [31:0] q;
        bus(1, ARR_OFS_B_LOW, {16'h0, ARR_IDX_B_HIGH, 9'h0}, 4'hf, q);
        bus(1, ARR_OFS_B_HIGH, {16'h0, ARR_IDX_B_LOW, 9'h0aa}, 4'hf, q);
        bus(1, ARR_OFS_B_HIGH, {16'h0, ARR_IDX_B_HIGH, 9'h0aa}, 4'hd, q);
        bus(1, 8'h20, {16'h0, 7'h08, 9'h0}, 4'hf, q);
        chk("code kept", {16'h0, range_code}, 32'h39c6);
        bus(0, 8'h20, 32'h0, 4'hf, q);
        chk("rd unmapped", q, 32'h0);
        $display("refuse test done");
    endtask
    initial begin
        t_reset();
        t_codes();
        t_refuse();
        t_reset();
        end_sim();
    end
endmodule
